// ---- src/servo_position_monitor.sv ----
// position window, rough match, soft stroke limit, s-curve and alarm history supervisor
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
module servo_position_monitor
  import servo_monitor_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  motion_in_t       motion_i,
  input  alarm_in_t        alarm_i,
  output logic             position_window_out_o,
  output logic             rough_match_out_o,
  output logic             positioning_complete_o,
  output logic             servo_lock_o,
  output logic             s_curve_active_o,
  output logic             param_error_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (MS_TICKS < 1) begin : g_bad_ticks
    $error("MS_TICKS must be at least one");
  end

  // refuse sizes that the decode and read-back paths cannot hold
  if (ALARM_DEPTH < 1 || ALARM_DEPTH > 8) begin : g_bad_depth
    $error("ALARM_DEPTH must lie between one and eight");
  end

  if (ALARM_W < 1 || ALARM_W > 32) begin : g_bad_alarm_w
    $error("ALARM_W must lie between one and thirty-two");
  end

  if (NUM_CFG > int'(IDX_ALARM_CLEAR)) begin : g_bad_cfg
    $error("configuration words overlap the clear word");
  end

  if (STATUS_W != ST_S_CURVE + 1 || STATUS_W > 32) begin : g_bad_status
    $error("status width does not match its field positions");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0]        cfg_ff [0:NUM_CFG-1];
  logic [ALARM_W-1:0] hist_ff [0:ALARM_DEPTH-1];
  logic               clear_req_ff;
  logic               ack_ff;
  logic [31:0]        dat_ff;
  logic               window_ff;
  logic               rough_ff;
  logic               complete_ff;
  logic               lock_ff;
  logic               s_curve_ff;
  logic               perr_ff;
  logic               done_d_ff;
  complete_state_t    cmp_state_ff;
  complete_state_t    nxt_cmp_state;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic        req       = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic        wr        = req && wb_we_i;
  wire logic [5:0]  word      = wb_adr_i[7:2];
  wire logic        in_cfg    = word < 6'(NUM_CFG);
  wire logic        hit_clear = word == {1'b0, IDX_ALARM_CLEAR};
  wire logic        hit_stat  = word == {1'b0, IDX_STATUS};
  wire logic        hit_hist  = word >= {1'b0, IDX_ALARM_HISTORY_0} &&
                                word <  6'({1'b0, IDX_ALARM_HISTORY_0} + 6'(ALARM_DEPTH));
  wire logic [4:0]  cfg_idx   = word[4:0];
  wire logic [2:0]  hist_idx  = 3'(word - {1'b0, IDX_ALARM_HISTORY_0});
  wire logic [15:0] lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [15:0] cfg_old   = in_cfg ? cfg_ff[cfg_idx] : 16'h0000;
  wire logic [15:0] cfg_new   = (cfg_old & ~lane_mask) | (wb_dat_i[15:0] & lane_mask);
  // out-of-range s-curve writes are dropped so the old time stays valid
  wire logic        s_ok      = cfg_new <= S_CURVE_MAX_MS;
  wire logic        cfg_we    = wr && in_cfg && (cfg_idx != IDX_S_CURVE_TIME || s_ok);

  // ----------------------------------------------------------------
  // address assembly
  // ----------------------------------------------------------------
  logic signed [31:0] win_plus;
  logic signed [31:0] win_minus;
  logic signed [31:0] soft_plus;
  logic signed [31:0] soft_minus;
  logic               err_wplus;
  logic               err_wminus;
  logic               err_splus;
  logic               err_sminus;

  split_address u_win_plus (
    .upper_i    (cfg_ff[IDX_WINDOW_PLUS_UPPER]),
    .lower_i    (cfg_ff[IDX_WINDOW_PLUS_LOWER]),
    .value_o    (win_plus),
    .sign_err_o (err_wplus)
  );

  split_address u_win_minus (
    .upper_i    (cfg_ff[IDX_WINDOW_MINUS_UPPER]),
    .lower_i    (cfg_ff[IDX_WINDOW_MINUS_LOWER]),
    .value_o    (win_minus),
    .sign_err_o (err_wminus)
  );

  split_address u_soft_plus (
    .upper_i    (cfg_ff[IDX_SOFT_PLUS_UPPER]),
    .lower_i    (cfg_ff[IDX_SOFT_PLUS_LOWER]),
    .value_o    (soft_plus),
    .sign_err_o (err_splus)
  );

  split_address u_soft_minus (
    .upper_i    (cfg_ff[IDX_SOFT_MINUS_UPPER]),
    .lower_i    (cfg_ff[IDX_SOFT_MINUS_LOWER]),
    .value_o    (soft_minus),
    .sign_err_o (err_sminus)
  );

  // ----------------------------------------------------------------
  // supervision terms
  // ----------------------------------------------------------------
  // an intermediate value shows while only the lower half is new
  wire logic signed [31:0] pos = motion_i.position;
  wire logic        err_order  = soft_plus < soft_minus;
  wire logic        any_err    = err_wplus || err_wminus || err_splus || err_sminus || err_order;
  wire logic        in_window  = pos >= win_minus && pos <= win_plus;
  wire logic        rough_hit  = motion_i.remaining <= {16'h0000, cfg_ff[IDX_ROUGH_MATCH_RANGE]};
  wire logic        soft_on    = soft_plus != soft_minus && !motion_i.home_return;
  wire logic        beyond     = pos > soft_plus || pos < soft_minus;
  wire logic        stop_now   = soft_on && beyond;
  wire logic [15:0] s_time     = cfg_ff[IDX_S_CURVE_TIME];
  wire logic        s_active   = s_time != 16'h0000;
  wire logic        done_rise  = motion_i.motion_done && !done_d_ff;
  wire logic        wait_start = done_rise && s_active;
  logic             wait_over;

  ms_delay #(
    .MS_TICKS (MS_TICKS)
  ) u_settle (
    .clk_i     (clk_i),
    .rst_i     (rst_i || !motion_i.motion_done),
    .start_i   (wait_start),
    .ms_i      (s_time),
    .expired_o (wait_over)
  );

  // ----------------------------------------------------------------
  // positioning complete sequencing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cmp_state = cmp_state_ff;
    case (cmp_state_ff)
      CMP_IDLE: begin
        if (done_rise) begin
          nxt_cmp_state = s_active ? CMP_WAIT : CMP_DONE;
        end
      end
      CMP_WAIT: begin
        if (!motion_i.motion_done) begin
          nxt_cmp_state = CMP_IDLE;
        end else if (wait_over) begin
          nxt_cmp_state = CMP_DONE;
        end
      end
      CMP_DONE: begin
        if (!motion_i.motion_done) begin
          nxt_cmp_state = CMP_IDLE;
        end
      end
      default: begin
        nxt_cmp_state = CMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_state_ff <= CMP_IDLE;
      done_d_ff    <= 1'b0;
    end else begin
      cmp_state_ff <= nxt_cmp_state;
      done_d_ff    <= motion_i.motion_done;
    end
  end

  // ----------------------------------------------------------------
  // configuration words
  // ----------------------------------------------------------------
  // reserved maker words are mapped like the others, so a bus write can change them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_ff[i] <= CFG_RESET[i];
      end
    end else if (cfg_we) begin
      cfg_ff[cfg_idx] <= cfg_new;
    end
  end

  // ----------------------------------------------------------------
  // alarm history
  // ----------------------------------------------------------------
  // rst_i stands for a power cycle; por_i always wipes the history and the clear request, rst_i wipes the history only after a clear request
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      clear_req_ff <= 1'b0;
      for (int i = 0; i < ALARM_DEPTH; i++) begin
        hist_ff[i] <= '0;
      end
    end else if (rst_i) begin
      if (clear_req_ff) begin
        for (int i = 0; i < ALARM_DEPTH; i++) begin
          hist_ff[i] <= '0;
        end
      end
      clear_req_ff <= 1'b0;
    end else begin
      if (wr && hit_clear && wb_sel_i[0]) begin
        clear_req_ff <= wb_dat_i[0];
      end
      if (alarm_i.event_pulse) begin
        hist_ff[0] <= alarm_i.code;
        for (int i = 1; i < ALARM_DEPTH; i++) begin
          hist_ff[i] <= hist_ff[i-1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_ff   <= 1'b0;
      rough_ff    <= 1'b0;
      complete_ff <= 1'b0;
      lock_ff     <= 1'b0;
      s_curve_ff  <= 1'b0;
      perr_ff     <= 1'b0;
    end else begin
      window_ff   <= in_window;
      rough_ff    <= rough_hit;
      complete_ff <= nxt_cmp_state == CMP_DONE;
      lock_ff     <= stop_now;
      s_curve_ff  <= s_active;
      perr_ff     <= any_err;
    end
  end

  assign position_window_out_o  = window_ff;
  assign rough_match_out_o      = rough_ff;
  assign positioning_complete_o = complete_ff;
  assign servo_lock_o           = lock_ff;
  assign s_curve_active_o       = s_curve_ff;
  assign param_error_o          = perr_ff;

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  wire logic [STATUS_W-1:0] status;

  assign status[ST_WINDOW]     = window_ff;
  assign status[ST_ROUGH]      = rough_ff;
  assign status[ST_COMPLETE]   = complete_ff;
  assign status[ST_SOFT_STOP]  = lock_ff;
  assign status[ST_ERR_WPLUS]  = err_wplus;
  assign status[ST_ERR_WMINUS] = err_wminus;
  assign status[ST_ERR_SPLUS]  = err_splus;
  assign status[ST_ERR_SMINUS] = err_sminus;
  assign status[ST_ERR_ORDER]  = err_order;
  assign status[ST_S_CURVE]    = s_curve_ff;

  wire logic [31:0] rd_cfg  = {16'h0000, cfg_old};
  wire logic [31:0] rd_clr  = {31'h0, clear_req_ff};
  wire logic [31:0] rd_stat = 32'(status);
  wire logic [31:0] rd_hist = hit_hist ? 32'(hist_ff[hist_idx]) : 32'h00000000;
  logic      [31:0] rd_data;

  // unmapped words fall through to zero
  always_comb begin
    rd_data = 32'h00000000;
    if (in_cfg) begin
      rd_data = rd_cfg;
    end else if (hit_clear) begin
      rd_data = rd_clr;
    end else if (hit_stat) begin
      rd_data = rd_stat;
    end else if (hit_hist) begin
      rd_data = rd_hist;
    end
  end

  // unmapped words read zero and ignore writes, but are still acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      dat_ff <= (req && !wb_we_i) ? rd_data : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

endmodule : servo_position_monitor

// ---- src/servo_monitor_pkg.sv ----
// shared constants, register map and types of the servo position monitor
package servo_monitor_pkg;

  // ----------------------------------------------------------------
  // register map (word index, byte address is index * 4)
  // ----------------------------------------------------------------
  localparam int          NUM_CFG                    = 24;
  localparam logic [4:0]  IDX_WINDOW_PLUS_LOWER      = 5'h00;
  localparam logic [4:0]  IDX_WINDOW_PLUS_UPPER      = 5'h01;
  localparam logic [4:0]  IDX_WINDOW_MINUS_LOWER     = 5'h02;
  localparam logic [4:0]  IDX_WINDOW_MINUS_UPPER     = 5'h03;
  localparam logic [4:0]  IDX_INPUT_AUTO_ON_SELECT_A = 5'h04;
  localparam logic [4:0]  IDX_INPUT_AUTO_ON_SELECT_C = 5'h05;
  localparam logic [4:0]  IDX_INPUT_AUTO_ON_SELECT_D = 5'h06;
  localparam logic [4:0]  IDX_INPUT_PIN_FUNCTION_B   = 5'h07;
  localparam logic [4:0]  IDX_INPUT_PIN_FUNCTION_C   = 5'h08;
  localparam logic [4:0]  IDX_INPUT_PIN_FUNCTION_D   = 5'h09;
  localparam logic [4:0]  IDX_OUTPUT_PIN_FUNCTION_A  = 5'h0A;
  localparam logic [4:0]  IDX_OUTPUT_PIN_FUNCTION_B  = 5'h0B;
  localparam logic [4:0]  IDX_OUTPUT_PIN_FUNCTION_C  = 5'h0C;
  localparam logic [4:0]  IDX_INPUT_POLARITY_SELECT  = 5'h0D;
  localparam logic [4:0]  IDX_INPUT_RESPONSE_LEVEL   = 5'h0E;
  localparam logic [4:0]  IDX_IO_FUNCTION_SELECT_1   = 5'h0F;
  localparam logic [4:0]  IDX_IO_FUNCTION_SELECT_2   = 5'h10;
  localparam logic [4:0]  IDX_IO_FUNCTION_SELECT_5   = 5'h11;
  localparam logic [4:0]  IDX_SOFT_PLUS_LOWER        = 5'h12;
  localparam logic [4:0]  IDX_SOFT_PLUS_UPPER        = 5'h13;
  localparam logic [4:0]  IDX_SOFT_MINUS_LOWER       = 5'h14;
  localparam logic [4:0]  IDX_SOFT_MINUS_UPPER       = 5'h15;
  localparam logic [4:0]  IDX_ROUGH_MATCH_RANGE      = 5'h16;
  localparam logic [4:0]  IDX_S_CURVE_TIME           = 5'h17;
  localparam logic [4:0]  IDX_ALARM_CLEAR            = 5'h18;
  localparam logic [4:0]  IDX_STATUS                 = 5'h19;
  localparam logic [4:0]  IDX_ALARM_HISTORY_0        = 5'h1A;

  // ----------------------------------------------------------------
  // reset values of the configuration words
  // ----------------------------------------------------------------
  localparam logic [15:0] CFG_RESET [0:NUM_CFG-1] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h002B,
    16'h000A, 16'h000B, 16'h0002, 16'h0003, 16'h0024, 16'h0000, 16'h0002, 16'h0010,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // ----------------------------------------------------------------
  // field positions and limits
  // ----------------------------------------------------------------
  localparam int          ST_WINDOW      = 0;
  localparam int          ST_ROUGH       = 1;
  localparam int          ST_COMPLETE    = 2;
  localparam int          ST_SOFT_STOP   = 3;
  localparam int          ST_ERR_WPLUS   = 4;
  localparam int          ST_ERR_WMINUS  = 5;
  localparam int          ST_ERR_SPLUS   = 6;
  localparam int          ST_ERR_SMINUS  = 7;
  localparam int          ST_ERR_ORDER   = 8;
  localparam int          ST_S_CURVE     = 9;
  localparam int          STATUS_W       = 10;
  localparam logic [15:0] S_CURVE_MAX_MS = 16'h03E8;
  localparam int          DIGIT_SCALE    = 1000;
  localparam int          HALF_MAX       = 999;
  localparam int          ALARM_DEPTH    = 6;
  localparam int          ALARM_W        = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ         = 50_000_000;
  localparam int          MS_PER_S       = 1000;
  localparam int          MS_CYCLES      = CLK_HZ / MS_PER_S;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [31:0] position;
    logic        [31:0] remaining;
    logic               home_return;
    logic               motion_done;
  } motion_in_t;

  typedef struct packed {
    logic               event_pulse;
    logic [ALARM_W-1:0] code;
  } alarm_in_t;

  typedef enum logic [2:0] {
    CMP_IDLE = 3'b001,
    CMP_WAIT = 3'b010,
    CMP_DONE = 3'b100
  } complete_state_t;

endpackage : servo_monitor_pkg

// ---- src/split_address.sv ----
// joins an upper and a lower three-digit half into one signed address
`timescale 1ns/1ns
module split_address
  import servo_monitor_pkg::*;
(
  input  wire logic        [15:0] upper_i,
  input  wire logic        [15:0] lower_i,
  output logic signed      [31:0] value_o,
  output logic                    sign_err_o
);
  wire logic signed [31:0] up_s  = 32'($signed(upper_i));
  wire logic signed [31:0] low_s = 32'($signed(lower_i));
  wire logic               up_neg  = up_s < 0;
  wire logic               up_pos  = up_s > 0;
  wire logic               low_neg = low_s < 0;
  wire logic               low_pos = low_s > 0;
  // halves beyond three digits are treated like a sign clash
  wire logic               over = (up_s > HALF_MAX) || (up_s < -HALF_MAX) ||
                                  (low_s > HALF_MAX) || (low_s < -HALF_MAX);

  assign value_o    = 32'(up_s * DIGIT_SCALE + low_s);
  assign sign_err_o = (up_neg && low_pos) || (up_pos && low_neg) || over;
endmodule : split_address

// ---- src/ms_delay.sv ----
// counts a programmable number of milliseconds after a start pulse
`timescale 1ns/1ns
module ms_delay
  import servo_monitor_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] ms_i,
  output logic             expired_o
);
  logic [31:0] tick_ff;
  logic [15:0] ms_left_ff;
  logic        busy_ff;
  wire  logic  tick_wrap = tick_ff == 32'(MS_TICKS - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) begin
      tick_ff    <= 32'h00000000;
      ms_left_ff <= rst_i ? 16'h0000 : ms_i;
      busy_ff    <= start_i && !rst_i;
    end else if (busy_ff) begin
      tick_ff <= tick_wrap ? 32'h00000000 : tick_ff + 32'h00000001;
      if (tick_wrap) begin
        ms_left_ff <= ms_left_ff - 16'h0001;
        busy_ff    <= ms_left_ff != 16'h0001;
      end
    end
  end

  assign expired_o = busy_ff && tick_wrap && ms_left_ff == 16'h0001;
endmodule : ms_delay

// ---- testbench/servo_position_monitor_assertions.sv ----
// port-level checker for the servo position monitor
`timescale 1ns/1ns
module servo_position_monitor_assertions
  import servo_monitor_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire motion_in_t  motion_i,
  input wire logic        rough_match_out_o,
  input wire logic        positioning_complete_o,
  input wire logic        servo_lock_o,
  input wire logic        s_curve_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------------------------------------------
  // checks
  // ------------------------------------------
  // first edge after reset is skipped: outputs are still cleared there
  sequence s_rise;
    !$past(rst_i) && $rose(motion_i.motion_done);
  endsequence
  sequence s_hold_low;
    !positioning_complete_o [*4];
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_rough_zero: assert property (!$past(rst_i) && motion_i.remaining == 32'h0 |=> rough_match_out_o)
    else $error("rough match low at zero distance");
  a_lock_home: assert property (motion_i.home_return |=> !servo_lock_o)
    else $error("lock during home return");
  a_complete_fall: assert property (!motion_i.motion_done |=> !positioning_complete_o)
    else $error("complete without motion done");
  a_linear_done: assert property (s_rise ##0 !s_curve_active_o |=> positioning_complete_o)
    else $error("linear complete late");
  a_s_curve_wait: assert property (s_rise ##0 s_curve_active_o |=> s_hold_low)
    else $error("s-curve complete too early");
endmodule : servo_position_monitor_assertions

bind servo_position_monitor servo_position_monitor_assertions #(.MS_TICKS(MS_TICKS)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .motion_i(motion_i), .rough_match_out_o(rough_match_out_o),
  .positioning_complete_o(positioning_complete_o), .servo_lock_o(servo_lock_o),
  .s_curve_active_o(s_curve_active_o));

// ---- testbench/motion_host_model.sv ----
// far-side motion and alarm source feeding the monitor
`timescale 1ns/1ns
module motion_host_model
  import servo_monitor_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic signed [31:0] pos_i,
  input  wire logic        [31:0] rem_i,
  input  wire logic               home_i,
  input  wire logic               done_i,
  input  wire logic               alarm_i,
  input  wire logic        [7:0]  code_i,
  output motion_in_t              motion_o,
  output alarm_in_t               alarm_o
);
  // registered, so every change lands just after an edge
  motion_in_t motion_ff = '0;
  alarm_in_t  alarm_ff = '0;
  always @(posedge clk_i) begin
    motion_ff <= '{pos_i, rem_i, home_i, done_i};
    alarm_ff <= '{alarm_i, code_i};
  end
  assign motion_o = motion_ff;
  assign alarm_o = alarm_ff;
endmodule : motion_host_model

// ---- testbench/servo_position_monitor_tb.sv ----
// self-checking bench for the servo position monitor
`timescale 1ns/1ns
module servo_position_monitor_tb
  import servo_monitor_pkg::*;
  ;
  localparam int      TICKS = 5;
  logic               clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
  logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [3:0]         sel = 4'h0;
  logic [31:0]        wdat = 32'h0, dat_o, rdat;
  logic               ack, win, rough, cmpl, lock, sact, perr;
  logic signed [31:0] pos = 32'sh0;
  logic [31:0]        rem = 32'h00010000;
  logic               home = 1'b0, done = 1'b0, alm = 1'b0;
  logic [7:0]         code = 8'h00;
  motion_in_t         motion;
  alarm_in_t          alarm;
  int                 miscompares = 0, total_checks = 0;
  int                 wpos [4] = '{-2, -1, 999999, 1000000};
  logic [3:0]         wexp = 4'h6;

  motion_host_model far (.clk_i(clk_i), .pos_i(pos), .rem_i(rem), .home_i(home), .done_i(done),
    .alarm_i(alm), .code_i(code), .motion_o(motion), .alarm_o(alarm));
  servo_position_monitor #(.MS_TICKS(TICKS)) uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .motion_i(motion), .alarm_i(alarm), .position_window_out_o(win),
    .rough_match_out_o(rough), .positioning_complete_o(cmpl), .servo_lock_o(lock),
    .s_curve_active_o(sact), .param_error_o(perr));

  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // request held until ack is sampled; bounded wait
  task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    if (ack !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(a, 1'b0, 16'h0000);
    chk(what, exp, rdat);
  endtask : rd

  initial begin
    int n;
    tick(3);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    // reserved maker words are never written
    for (int i = 4; i < 18; i++) rd(8'(i * 4), {16'h0, CFG_RESET[i]}, "reset value");
    rd(8'hFC, 32'h0, "unmapped");
    $display("register test done");
    wr_pair(8'h00, 16'h03E7, 16'h03E7);
    wr_pair(8'h08, 16'hFFFF, 16'h0000);
    foreach (wpos[i]) begin
      pos <= wpos[i];
      tick(3);
      chk("window", wexp[i], win);
    end
    wb(8'h04, 1'b1, 16'hFFFF);
    tick(3);
    chk("win+ sign", 1, perr);
    wb(8'h04, 1'b1, 16'h03E7);
    wb(8'h0C, 1'b1, 16'h0001);
    tick(3);
    chk("win- sign", 1, perr);
    wb(8'h0C, 1'b1, 16'h0000);
    tick(3);
    chk("no error", 0, perr);
    $display("window test done");
    wb(8'h58, 1'b1, 16'hFFFF);
    rem <= 32'h0;
    tick(3);
    chk("rough zero", 1, rough);
    rem <= 32'h0000FFFF;
    tick(3);
    chk("rough max", 1, rough);
    rem <= 32'h00010000;
    tick(3);
    chk("rough beyond", 0, rough);
    $display("rough test done");
    wb(8'h48, 1'b1, 16'h0064);
    wb(8'h50, 1'b1, 16'hFF9C);
    pos <= 101;
    tick(3);
    chk("lock over", 1, lock);
    pos <= 100;
    tick(3);
    chk("lock at limit", 0, lock);
    pos <= -101;
    home <= 1'b1;
    tick(3);
    chk("lock homing", 0, lock);
    home <= 1'b0;
    tick(3);
    chk("lock under", 1, lock);
    wb(8'h50, 1'b1, 16'h0064);
    tick(3);
    chk("lock equal", 0, lock);
    wb(8'h50, 1'b1, 16'h00C8);
    tick(3);
    chk("order error", 1, perr);
    wb(8'h64, 1'b0, 16'h0000);
    chk("order bit", 1, rdat[8]);
    wb(8'h50, 1'b1, 16'h0064);
    $display("limit test done");
    wb(8'h5C, 1'b1, 16'h03E9);
    rd(8'h5C, 32'h0, "s time refused");
    wb(8'h5C, 1'b1, 16'h03E8);
    rd(8'h5C, 32'h03E8, "s time max");
    wb(8'h5C, 1'b1, 16'h0002);
    tick(2);
    chk("s active", 1, sact);
    done <= 1'b1;
    tick(9);
    chk("s hold", 0, cmpl);
    n = 0;
    while (cmpl !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk("s complete", 1, cmpl);
    if (cmpl !== 1'b1) begin
      final_report();
    end
    done <= 1'b0;
    wb(8'h5C, 1'b1, 16'h0000);
    tick(3);
    chk("linear", 0, sact);
    done <= 1'b1;
    tick(3);
    chk("linear complete", 1, cmpl);
    $display("s-curve test done");
    for (int i = 1; i <= 7; i++) begin
      alm <= 1'b1;
      code <= 8'(i);
      tick(1);
      alm <= 1'b0;
      tick(1);
    end
    tick(3);
    rd(8'h68, 32'h7, "history current");
    rd(8'h7C, 32'h2, "history oldest");
    wb(8'h60, 1'b1, 16'h0001);
    rd(8'h68, 32'h7, "history kept");
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    rd(8'h60, 32'h0, "clear request");
    rd(8'h68, 32'h0, "history cleared");
    $display("alarm test done");
    final_report();
  end
  // lower half first, then upper half
  task automatic wr_pair(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
    wb(a, 1'b1, lo);
    wb(a + 8'h04, 1'b1, hi);
  endtask : wr_pair
endmodule : servo_position_monitor_tb
